/* rtl/pao_chg_det.sv */
// per-bit change detector with a per-bit enable
`timescale 1ns/1ps
`default_nettype none
module pao_chg_det #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // sampled level and enables
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] enable,
  // one-cycle change pulses
  output logic [WIDTH-1:0] change
);
  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  assign change = enable & (level ^ prev_reg);
endmodule
`default_nettype wire

/* rtl/pao_override.sv */
// port A alternate function override logic with APB control and status
// Functional notes
// - only bits 7, 6, 3 raise the shared pin-change interrupt, outputs included.
// - only bits 7, 6, 3 get input-enable override; others no other override.
// - bit 3 alone has driver and pull-up overridden besides input enable.
// - bits 7, 6 input override enable is irq enable and comparator disabled.
// - bit 7 input stays enabled in sleep when its interrupt is enabled.
// - bit 6 input stays enabled in sleep when its interrupt is enabled.
// - bit 3 input stays enabled in sleep when its interrupt is enabled and it is not used as reference.
// - reference select bit0 forces bit 3 pull-up and driver off.
// - bit 3 input override enable is irq enable and reference select clear.
// - port irq enable needs global flag, pin-change enable, no masking function.
// - bits 0,1,2,4,5,6,7 map to channels 0..6; comparator and reference too.
// - input enable follows override value when enabled, otherwise sleep state.
// - pull-up follows override value regardless of direction, output, disable.
// - sleep clamps inputs unless an override keeps them enabled.
`timescale 1ns/1ps
`default_nettype none
`include "pao_cfg.svh"
module pao_override (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pads and generic port logic
  input wire logic [7:0] PAD_IN,
  input wire logic [7:0] PORT_DIR,
  input wire logic [7:0] PORT_OUT,
  input wire logic PULLUP_DISABLE,
  input wire logic SLEEP_CLAMP,
  // override signals
  output logic [7:0] PULLUP_OVERRIDE_EN,
  output logic [7:0] PULLUP_OVERRIDE_VAL,
  output logic [7:0] DIRECTION_OVERRIDE_EN,
  output logic [7:0] DIRECTION_OVERRIDE_VAL,
  output logic [7:0] OUTVALUE_OVERRIDE_EN,
  output logic [7:0] OUTVALUE_OVERRIDE_VAL,
  output logic [7:0] INPUT_ENABLE_OVERRIDE_EN,
  output logic [7:0] INPUT_ENABLE_OVERRIDE_VAL,
  // resolved pin controls
  output logic [7:0] PIN_PULLUP_EN,
  output logic [7:0] PIN_DRIVE_EN,
  output logic [7:0] PIN_DRIVE_VAL,
  output logic [7:0] PIN_INPUT_EN,
  // analog switch enables
  output logic [7:0] CONV_CHAN_CONNECT,
  output logic COMPARATOR_POS_INPUT,
  output logic COMPARATOR_NEG_INPUT,
  output logic CONVERTER_REFERENCE_PIN,
  // interrupts
  output logic SHARED_PIN_CHANGE_IRQ,
  output logic IRQ
);
  logic [`PAO_CTRL_W-1:0] ctrl_reg;
  logic [`PAO_EVT_W-1:0] status_reg;
  logic [`PAO_EVT_W-1:0] mask_reg;
  logic [`PAO_EVT_W-1:0] status_next;
  pao_pkg::pao_pins_type pad_sync;
  pao_pkg::pao_pins_type pin_change;
  pao_pkg::pao_pins_type pci_enable;
  pao_pkg::pao_pins_type die_oe;
  pao_pkg::pao_pins_type die_ov;
  pao_pkg::pao_pins_type pu_oe;
  pao_pkg::pao_pins_type dd_oe;
  pao_pkg::pao_pins_type chan_connect;
  pao_pkg::pao_chan_type chan_sel;
  logic gie;
  logic pce;
  logic comparator_disable_bit;
  logic reference_select_bit0;
  logic port_irq_enable;
  logic pchg_event;
  logic setup_phase;
  logic wr_access;
  logic addr_ok;
  logic [31:0] rd_data;

  assign gie = ctrl_reg[`PAO_CTRL_GIE];
  assign pce = ctrl_reg[`PAO_CTRL_PCE];
  assign comparator_disable_bit = ctrl_reg[`PAO_CTRL_CMP_DIS];
  assign reference_select_bit0 = ctrl_reg[`PAO_CTRL_REF_SEL0];
  assign chan_sel = ctrl_reg[`PAO_CTRL_CH_HI:`PAO_CTRL_CH_LO];

  // apb decode; every access is answered in its first access cycle
  assign setup_phase = PSEL && !PENABLE;
  assign wr_access = PSEL && PENABLE && PREADY && PWRITE;
  assign addr_ok = (PADDR == `PAO_OFS_CTRL) || (PADDR == `PAO_OFS_STATUS) ||
                   (PADDR == `PAO_OFS_MASK) || (PADDR == `PAO_OFS_PINS);

  always_comb begin
    rd_data = 32'h00000000;
    case (PADDR)
      `PAO_OFS_CTRL: begin
        rd_data[`PAO_CTRL_W-1:0] = ctrl_reg;
      end
      `PAO_OFS_STATUS: begin
        rd_data[`PAO_EVT_W-1:0] = status_reg;
      end
      `PAO_OFS_MASK: begin
        rd_data[`PAO_EVT_W-1:0] = mask_reg;
      end
      `PAO_OFS_PINS: begin
        rd_data[`PAO_PINS_IN_LO+7:`PAO_PINS_IN_LO] = pad_sync;
        rd_data[`PAO_PINS_EN_LO+7:`PAO_PINS_EN_LO] = PIN_INPUT_EN;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= setup_phase;
      PSLVERR <= setup_phase && !addr_ok;
      if (setup_phase && !PWRITE) begin
        PRDATA <= rd_data;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= `PAO_CTRL_RST;
    end else if (wr_access && PADDR == `PAO_OFS_CTRL) begin
      ctrl_reg <= PWDATA[`PAO_CTRL_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_reg <= `PAO_EVT_RST;
    end else if (wr_access && PADDR == `PAO_OFS_MASK) begin
      mask_reg <= PWDATA[`PAO_EVT_W-1:0];
    end
  end

  // write-one-to-clear; a change in the clearing cycle keeps the flag set
  always_comb begin
    status_next = status_reg;
    if (wr_access && PADDR == `PAO_OFS_STATUS) begin
      status_next = status_reg & ~PWDATA[`PAO_EVT_W-1:0];
    end
    status_next[`PAO_EVT_PCHG] = status_next[`PAO_EVT_PCHG] | pchg_event;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_reg <= `PAO_EVT_RST;
      IRQ <= 1'b0;
    end else begin
      status_reg <= status_next;
      IRQ <= |(status_next & mask_reg);
    end
  end

  // interrupt enable and per-pin masking by the alternate functions
  assign port_irq_enable = gie && pce;
  always_comb begin
    pci_enable = 8'h00;
    pci_enable[`PAO_BIT_CMP_NEG] = port_irq_enable && comparator_disable_bit;
    pci_enable[`PAO_BIT_CMP_POS] = port_irq_enable && comparator_disable_bit;
    pci_enable[`PAO_BIT_REF] = port_irq_enable && !reference_select_bit0;
  end

  assign die_oe = pci_enable & `PAO_PCI_PINS;
  assign die_ov = `PAO_PCI_PINS;
  assign pu_oe = reference_select_bit0 ? `PAO_REF_PINS : 8'h00;
  assign dd_oe = reference_select_bit0 ? `PAO_REF_PINS : 8'h00;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PULLUP_OVERRIDE_EN <= 8'h00;
      PULLUP_OVERRIDE_VAL <= 8'h00;
      DIRECTION_OVERRIDE_EN <= 8'h00;
      DIRECTION_OVERRIDE_VAL <= 8'h00;
      OUTVALUE_OVERRIDE_EN <= 8'h00;
      OUTVALUE_OVERRIDE_VAL <= 8'h00;
      INPUT_ENABLE_OVERRIDE_EN <= 8'h00;
      INPUT_ENABLE_OVERRIDE_VAL <= 8'h00;
    end else begin
      PULLUP_OVERRIDE_EN <= pu_oe;
      PULLUP_OVERRIDE_VAL <= 8'h00;
      DIRECTION_OVERRIDE_EN <= dd_oe;
      DIRECTION_OVERRIDE_VAL <= 8'h00;
      OUTVALUE_OVERRIDE_EN <= 8'h00;
      OUTVALUE_OVERRIDE_VAL <= 8'h00;
      INPUT_ENABLE_OVERRIDE_EN <= die_oe;
      INPUT_ENABLE_OVERRIDE_VAL <= die_ov;
    end
  end

  // resolved controls as the generic pin logic applies them
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIN_PULLUP_EN <= 8'h00;
      PIN_DRIVE_EN <= 8'h00;
      PIN_DRIVE_VAL <= 8'h00;
      PIN_INPUT_EN <= 8'h00;
    end else begin
      PIN_PULLUP_EN <= (pu_oe & 8'h00) |
                       (~pu_oe & ~PORT_DIR & PORT_OUT & {8{!PULLUP_DISABLE}});
      PIN_DRIVE_EN <= (dd_oe & 8'h00) | (~dd_oe & PORT_DIR);
      PIN_DRIVE_VAL <= PORT_OUT;
      PIN_INPUT_EN <= (die_oe & die_ov) | (~die_oe & {8{!SLEEP_CLAMP}});
    end
  end

  // converter channel map over bits 0,1,2,4,5,6,7
  always_comb begin
    chan_connect = 8'h00;
    case (chan_sel)
      3'h0: chan_connect[0] = 1'b1;
      3'h1: chan_connect[1] = 1'b1;
      3'h2: chan_connect[2] = 1'b1;
      3'h3: chan_connect[4] = 1'b1;
      3'h4: chan_connect[5] = 1'b1;
      3'h5: chan_connect[6] = 1'b1;
      3'h6: chan_connect[7] = 1'b1;
      default: chan_connect = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CONV_CHAN_CONNECT <= 8'h00;
      COMPARATOR_POS_INPUT <= 1'b0;
      COMPARATOR_NEG_INPUT <= 1'b0;
      CONVERTER_REFERENCE_PIN <= 1'b0;
    end else begin
      CONV_CHAN_CONNECT <= chan_connect;
      COMPARATOR_POS_INPUT <= !comparator_disable_bit;
      COMPARATOR_NEG_INPUT <= !comparator_disable_bit;
      CONVERTER_REFERENCE_PIN <= reference_select_bit0;
    end
  end

  // pin-change path: pads are synchronised, gated by input enable
  pao_sync #(
    .WIDTH(8)
  ) u_pad_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .async_in(PAD_IN),
    .sync_out(pad_sync)
  );

  pao_chg_det #(
    .WIDTH(8)
  ) u_chg_det (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .level(pad_sync & PIN_INPUT_EN),
    .enable(pci_enable),
    .change(pin_change)
  );

  assign pchg_event = |(pin_change & `PAO_PCI_PINS);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SHARED_PIN_CHANGE_IRQ <= 1'b0;
    end else begin
      SHARED_PIN_CHANGE_IRQ <= pchg_event;
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  only_pci_pins_a: assert property (
    SHARED_PIN_CHANGE_IRQ |-> $past(|(pci_enable & `PAO_PCI_PINS)))
    else $error("pin change raised with no enabled pin");
  die_pins_only_a: assert property (
    (INPUT_ENABLE_OVERRIDE_EN & ~`PAO_PCI_PINS) == 8'h00 && OUTVALUE_OVERRIDE_EN == 8'h00)
    else $error("override on a pin without one");
  bit3_only_a: assert property (
    ((PULLUP_OVERRIDE_EN | DIRECTION_OVERRIDE_EN) & ~`PAO_REF_PINS) == 8'h00)
    else $error("driver or pull-up override off bit 3");
  cmp_mask_a: assert property (
    (gie && pce && !comparator_disable_bit) |=>
      !INPUT_ENABLE_OVERRIDE_EN[7] && !INPUT_ENABLE_OVERRIDE_EN[6])
    else $error("comparator did not mask the pin change");
  sleep_bit7_a: assert property (
    (SLEEP_CLAMP && gie && pce && comparator_disable_bit) |=> PIN_INPUT_EN[7])
    else $error("bit 7 input clamped while enabled");
  sleep_bit6_a: assert property (
    (SLEEP_CLAMP && gie && pce && comparator_disable_bit) |=> PIN_INPUT_EN[6])
    else $error("bit 6 input clamped while enabled");
  sleep_bit3_a: assert property (
    (SLEEP_CLAMP && gie && pce && !reference_select_bit0) |=> PIN_INPUT_EN[3])
    else $error("bit 3 input clamped while enabled");
  ref_off_a: assert property (
    reference_select_bit0 |=> PULLUP_OVERRIDE_EN[3] && DIRECTION_OVERRIDE_EN[3] &&
              !PIN_PULLUP_EN[3] && !PIN_DRIVE_EN[3])
    else $error("reference pin still drives or pulls up");
  ref_mask_a: assert property (
    (gie && pce) |=> (INPUT_ENABLE_OVERRIDE_EN[3] == !$past(reference_select_bit0)))
    else $error("bit 3 input override wrong");
  irq_gate_a: assert property (
    !(gie && pce) |=> INPUT_ENABLE_OVERRIDE_EN == 8'h00)
    else $error("override without port irq enable");
  chan_map_a: assert property (
    (chan_sel == 3'h3) |=> CONV_CHAN_CONNECT == 8'h10)
    else $error("channel 3 not on bit 4");
  sleep_clamp_a: assert property (
    (SLEEP_CLAMP && !(gie && pce)) |=> PIN_INPUT_EN == 8'h00)
    else $error("input not clamped in sleep");
  flag_set_a: assert property (
    pchg_event |=> status_reg[`PAO_EVT_PCHG] && SHARED_PIN_CHANGE_IRQ)
    else $error("pin change not flagged");
  irq_level_a: assert property (
    (status_reg[`PAO_EVT_PCHG] && mask_reg[`PAO_EVT_PCHG]) |-> ##[0:1] IRQ)
    else $error("masked-in flag without interrupt");

  pchg_seen_c: cover property (pchg_event ##1 IRQ);
  sleep_keep_c: cover property (SLEEP_CLAMP && PIN_INPUT_EN[7]);
  ref_used_c: cover property (reference_select_bit0 ##1 DIRECTION_OVERRIDE_EN[3]);
  clear_race_c: cover property (wr_access && PADDR == `PAO_OFS_STATUS && pchg_event);
endmodule
`default_nettype wire

/* rtl/pao_sync.sv */
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module pao_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

/* shared/pao_cfg.svh */
// register map, field positions and reset values of the port A override block
`ifndef PAO_CFG_SVH
`define PAO_CFG_SVH

`define PAO_OFS_CTRL 8'h00
`define PAO_OFS_STATUS 8'h04
`define PAO_OFS_MASK 8'h08
`define PAO_OFS_PINS 8'h0C

`define PAO_CTRL_GIE 0
`define PAO_CTRL_PCE 1
`define PAO_CTRL_CMP_DIS 2
`define PAO_CTRL_REF_SEL0 3
`define PAO_CTRL_CH_LO 4
`define PAO_CTRL_CH_HI 6
`define PAO_CTRL_W 7
`define PAO_CTRL_RST 7'h00

`define PAO_EVT_PCHG 0
`define PAO_EVT_W 1
`define PAO_EVT_RST 1'h0

`define PAO_PINS_IN_LO 0
`define PAO_PINS_EN_LO 8

`define PAO_BIT_CMP_NEG 7
`define PAO_BIT_CMP_POS 6
`define PAO_BIT_REF 3

`define PAO_PCI_PINS 8'hC8
`define PAO_REF_PINS 8'h08
`define PAO_CH_NONE 3'h7

`endif

/* shared/pao_pkg.sv */
// types shared by the port A override block
`default_nettype none
package pao_pkg;
  typedef logic [7:0] pao_pins_type;
  typedef logic [2:0] pao_chan_type;
endpackage
`default_nettype wire

/* test/pao_pad_model.sv */
// pad and generic pin model that resolves the port A pad levels
`timescale 1ns/1ps
`default_nettype none
module pao_pad_model (
  // far-side source, always driving each pad
  input wire logic [7:0] ext_level,
  // resolved pin controls from the block
  input wire logic [7:0] pin_drive_en,
  input wire logic [7:0] pin_drive_val,
  // pad levels
  output logic [7:0] pad_level
);
  // an enabled output driver overpowers the external source
  assign pad_level = (pin_drive_en & pin_drive_val) | (~pin_drive_en & ext_level);
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the port A override block
`timescale 1ns/1ps
`default_nettype none
`include "pao_cfg.svh"
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pud = 1'b0;
  logic clamp = 1'b0, pready, pslverr, er, pulse, irq, cp, cn, cr;
  logic [7:0] paddr = 8'h00, dir = 8'h00, pout = 8'h00, ext = 8'h00, pad;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] pullup_override_en, pullup_override_val, direction_override_en, direction_override_val, outvalue_override_en, outvalue_override_val, ieoe, ieov, pu, de, dv, ie, cc;
  logic [3:0] corner [4] = '{4'h7, 4'hF, 4'hB, 4'h3};
  int failures = 0, n_tests = 0, cyc = 0, npul = 0, seed = 32'h3e1b;

  pao_override i_dut (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PAD_IN(pad), .PORT_DIR(dir), .PORT_OUT(pout),
    .PULLUP_DISABLE(pud), .SLEEP_CLAMP(clamp), .PULLUP_OVERRIDE_EN(pullup_override_en),
    .PULLUP_OVERRIDE_VAL(pullup_override_val), .DIRECTION_OVERRIDE_EN(direction_override_en),
    .DIRECTION_OVERRIDE_VAL(direction_override_val), .OUTVALUE_OVERRIDE_EN(outvalue_override_en),
    .OUTVALUE_OVERRIDE_VAL(outvalue_override_val), .INPUT_ENABLE_OVERRIDE_EN(ieoe),
    .INPUT_ENABLE_OVERRIDE_VAL(ieov), .PIN_PULLUP_EN(pu), .PIN_DRIVE_EN(de),
    .PIN_DRIVE_VAL(dv), .PIN_INPUT_EN(ie), .CONV_CHAN_CONNECT(cc),
    .COMPARATOR_POS_INPUT(cp), .COMPARATOR_NEG_INPUT(cn),
    .CONVERTER_REFERENCE_PIN(cr), .SHARED_PIN_CHANGE_IRQ(pulse), .IRQ(irq));

  pao_pad_model i_pad (.ext_level(ext), .pin_drive_en(de), .pin_drive_val(dv),
    .pad_level(pad));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) npul <= npul + 1;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  function automatic logic [7:0] ieoe_f(input logic [6:0] c);
    logic en;
    en = c[0] & c[1];
    return {en & c[2], en & c[2], 2'b00, en & ~c[3], 3'b000};
  endfunction

  function automatic logic [7:0] chan_f(input logic [2:0] ch);
    logic [7:0] m;
    m = 8'h00;
    if (ch < 3'h3) m[ch] = 1'b1;
    else if (ch != 3'h7) m[ch + 3'h1] = 1'b1;
    return m;
  endfunction

  function automatic logic [7:0] drv_f(input logic [6:0] c, input logic [7:0] d);
    return c[3] ? (d & 8'hF7) : d;
  endfunction

  function automatic logic [7:0] pad_f(input logic [6:0] c, input logic [7:0] d,
    input logic [7:0] o, input logic [7:0] e);
    return (drv_f(c, d) & o) | (~drv_f(c, d) & e);
  endfunction

  task run_all;
    logic [6:0] c;
    logic [7:0] mie, pb, pa, chg, pue;
    logic msk;
    int pn;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk("reset_val", 32'h0, rd);
    end
    for (int i = 0; i < 40; i++) begin
      c = 7'($random(seed));
      c[6:4] = i[2:0];
      if (i < 4) c[3:0] = corner[i];
      msk = 1'($random(seed));
      dir <= ((i < 4) ? 8'hFF : 8'($random(seed))) & ~chan_f(c[6:4]);
      {clamp, pud} <= 2'($random(seed)) | {i < 4, 1'b0};
      apb(1'b1, `PAO_OFS_CTRL, {25'h0, c});
      apb(1'b1, `PAO_OFS_MASK, {31'h0, msk});
      repeat (6) @(posedge clk);
      apb(1'b1, `PAO_OFS_STATUS, 32'h1);
      pn = npul;
      pb = pad_f(c, dir, pout, ext);
      ext <= ext ^ 8'($random(seed));
      pout <= (pout ^ 8'($random(seed))) & ~chan_f(c[6:4]);
      repeat (6) @(posedge clk);
      mie = ieoe_f(c);
      pa = pad_f(c, dir, pout, ext);
      chg = (pb ^ pa) & mie;
      pue = ~dir & pout & {8{~pud}} & ~{4'h0, c[3], 3'h0};
      chk("ie_oe", mie, ieoe);
      chk("ie_ov", 8'hC8, ieov);
      chk("pu_oe", {4'h0, c[3], 3'h0}, pullup_override_en);
      chk("dd_oe", {4'h0, c[3], 3'h0}, direction_override_en);
      chk("ov_vals", 32'h0, {pullup_override_val, direction_override_val, outvalue_override_en, outvalue_override_val});
      chk("pin_pu", pue, pu);
      chk("pin_de", drv_f(c, dir), de);
      chk("pin_dv", pout, dv);
      chk("pin_ie", mie | {8{~clamp}}, ie);
      chk("chan", chan_f(c[6:4]), cc);
      chk("analog", {~c[2], ~c[2], c[3]}, {cp, cn, cr});
      chk("pulse", chg != 8'h00, npul != pn);
      chk("irq", (chg != 8'h00) & msk, irq);
      apb(1'b0, `PAO_OFS_PINS, 32'h0);
      chk("pins", {16'h0, mie | {8{~clamp}}, pa}, rd);
      apb(1'b0, `PAO_OFS_STATUS, 32'h0);
      chk("status", chg != 8'h00, rd);
      chk("slverr", 32'h0, er);
      apb(1'b1, `PAO_OFS_STATUS, 32'h1);
      apb(1'b0, `PAO_OFS_STATUS, 32'h0);
      chk("w1c", 32'h0, rd);
      chk("irq_clr", 32'h0, irq);
    end
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    chk("wr_err", 32'h1, er);
    apb(1'b0, 8'h10, 32'h0);
    chk("rd_err", 32'h1, er);
    chk("rd_unmapped", 32'h0, rd);
  endtask

  initial begin
    fork
      run_all();
      begin
        wait (cyc == 20000);
        failures++;
      end
    join_any
    summarize();
  end
endmodule
`default_nettype wire
